/* File: code_word_framer_pkg.sv */
package code_word_framer_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET     = 8'h00;
  localparam logic [7:0] SERIAL_OFFSET   = 8'h04;
  localparam logic [7:0] HOP_PUSH_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET   = 8'h0C;

  // Control fields and reset values
  localparam int          CTRL_ENABLE_BIT = 0;
  localparam int          CTRL_BLANK_BIT  = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h0;
  localparam logic [27:0] SERIAL_RESET    = 28'h0000000;
  localparam logic [31:0] HOP_RESET       = 32'h00000000;

  // Status fields
  localparam int STATUS_STATE_LSB    = 0;
  localparam int STATUS_REPEAT_BIT   = 3;
  localparam int STATUS_SHUTOFF_BIT  = 4;
  localparam int STATUS_TXACT_BIT    = 5;
  localparam int STATUS_FIFO_CNT_LSB = 8;

  // Word layout and element counts
  localparam int         WORD_BITS       = 66;
  localparam int         HOP_BITS        = 32;
  localparam int         SERIAL_BITS     = 28;
  localparam logic [7:0] PREAMBLE_ELEMS  = 8'h17;
  localparam logic [7:0] HEADER_ELEMS    = 8'h0A;
  localparam logic [7:0] DATA_ELEMS      = 8'hC6;
  localparam logic [7:0] GUARD_ELEMS     = 8'h27;
  localparam logic [1:0] ELEMS_PER_BIT   = 2'h3;

  // Timing in printed units and derived cycle counts
  localparam int CLK_MHZ            = 100;
  localparam int TE_NORMAL_US       = 400;
  localparam int TE_BLANK_US        = 200;
  localparam int TE_NORMAL_CYCLES   = TE_NORMAL_US * CLK_MHZ;
  localparam int TE_BLANK_CYCLES    = TE_BLANK_US * CLK_MHZ;
  localparam int MS_CYCLES          = 1000 * CLK_MHZ;
  localparam int DEBOUNCE_MS        = 10;
  localparam int TRANSMIT_DELAY_MS  = 18;
  localparam int SHUTOFF_MS         = 60000;

  localparam int FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_DEBOUNCE = 3'b001,
    ST_DELAY    = 3'b010,
    ST_PREAMBLE = 3'b011,
    ST_HEADER   = 3'b100,
    ST_DATA     = 3'b101,
    ST_GUARD    = 3'b110,
    ST_LOCKOUT  = 3'b111
  } framer_state_type;

endpackage

/* File: code_word_transmit_framer.sv */
`timescale 1ns/1ps

module hop_code_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_i,
  // Fill side
  input  wire logic                     in_valid_i,
  output logic                          in_ready_o,
  input  wire logic [WIDTH-1:0]         in_data_i,
  // Drain side
  output logic                          out_valid_o,
  input  wire logic                     out_ready_i,
  output logic [WIDTH-1:0]              out_data_o,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0]    count_o
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0]    cnt_q, cnt_d;
  logic             push, pop;

  always_comb begin
    push  = in_valid_i && (cnt_q != CW'(DEPTH));
    pop   = out_ready_i && (cnt_q != '0);
    wr_d  = push ? ((wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d  = pop ? ((rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  assign in_ready_o  = (cnt_q != CW'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign count_o     = cnt_q;
endmodule // hop_code_fifo

module code_word_transmit_framer
  import code_word_framer_pkg::*;
#(
  parameter int TE_NORMAL     = code_word_framer_pkg::TE_NORMAL_CYCLES,
  parameter int TE_BLANK      = code_word_framer_pkg::TE_BLANK_CYCLES,
  parameter int MS_LEN        = code_word_framer_pkg::MS_CYCLES,
  parameter int DEBOUNCE_LEN  = code_word_framer_pkg::DEBOUNCE_MS,
  parameter int DELAY_LEN     = code_word_framer_pkg::TRANSMIT_DELAY_MS,
  parameter int SHUTOFF_LEN   = code_word_framer_pkg::SHUTOFF_MS
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  // Buttons and supply monitor
  input  wire logic        button_in_zero_i,
  input  wire logic        button_in_one_i,
  input  wire logic        button_in_two_i,
  input  wire logic        low_battery_i,
  // Transmit output
  output logic             pwm_o,
  output logic             tx_active_o
);
  import code_word_framer_pkg::*;

  localparam int FCW = $clog2(FIFO_DEPTH+1);

  // Register file
  logic [1:0]  ctrl_q, ctrl_d;
  logic [27:0] serial_q, serial_d;
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic        fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [31:0] fifo_out_data;
  logic [FCW-1:0] fifo_count;
  logic        wr_commit, hop_push;
  logic        mapped;

  // Sequencer state
  framer_state_type state_q, state_d;
  logic [16:0] te_cnt_q, te_cnt_d;
  logic [7:0]  elem_q, elem_d;
  logic [1:0]  phase_q, phase_d;
  logic [WORD_BITS-1:0] word_q, word_d;
  logic [31:0] hop_q, hop_d;
  logic [3:0]  code;
  logic [2:0]  ext, pressed_q, pressed_d;
  logic        repeat_q, repeat_d, blank_q, blank_d, shutoff_q, shutoff_d;
  logic [7:0]  ms_q, ms_d;
  logic [15:0] shut_q, shut_d;
  logic [16:0] tick_cnt_q, tick_cnt_d;
  logic        pwm_q, pwm_d, txact_q, txact_d;
  logic        ms_tick, te_tick, start, restart, in_tx;
  logic [16:0] te_len;
  logic [3:0]  btn;

  hop_code_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (hop_push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (pwdata_i),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out_data),
    .count_o     (fifo_count)
  );

  // APB: writes commit at the edge where pready is sampled high
  always_comb begin
    mapped    = (paddr_i == CTRL_OFFSET) || (paddr_i == SERIAL_OFFSET) ||
                (paddr_i == HOP_PUSH_OFFSET) || (paddr_i == STATUS_OFFSET);
    wr_commit = psel_i && penable_i && pready_q && pwrite_i;
    hop_push  = wr_commit && (paddr_i == HOP_PUSH_OFFSET);
    ctrl_d    = (wr_commit && paddr_i == CTRL_OFFSET) ? pwdata_i[1:0] : ctrl_q;
    serial_d  = (wr_commit && paddr_i == SERIAL_OFFSET) ? pwdata_i[27:0] : serial_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = 32'h00000000;
    if (psel_i && penable_i && !pready_q) begin
      // A push into a full FIFO stalls the bus until a word drains
      pready_d  = !(pwrite_i && paddr_i == HOP_PUSH_OFFSET && !fifo_in_ready);
      pslverr_d = pready_d && !mapped;
      if (!pwrite_i) begin
        case (paddr_i)
          CTRL_OFFSET:   prdata_d = {30'h00000000, ctrl_q};
          SERIAL_OFFSET: prdata_d = {4'h0, serial_q};
          STATUS_OFFSET: begin
            prdata_d[STATUS_STATE_LSB +: 3]         = state_q;
            prdata_d[STATUS_REPEAT_BIT]             = repeat_q;
            prdata_d[STATUS_SHUTOFF_BIT]            = shutoff_q;
            prdata_d[STATUS_TXACT_BIT]              = txact_q;
            prdata_d[STATUS_FIFO_CNT_LSB +: FCW]    = fifo_count;
          end
          default:       prdata_d = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_q    <= CTRL_RESET;
      serial_q  <= SERIAL_RESET;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      ctrl_q    <= ctrl_d;
      serial_q  <= serial_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // Sequencer
  always_comb begin
    // External to internal button code: {three, two, one, zero}
    btn[3] = button_in_two_i;
    btn[2] = button_in_two_i;
    btn[1] = button_in_one_i | (button_in_two_i & button_in_zero_i);
    btn[0] = button_in_zero_i & (~button_in_two_i | button_in_one_i);
    ext    = {button_in_two_i, button_in_one_i, button_in_zero_i};
    in_tx  = (state_q == ST_PREAMBLE) || (state_q == ST_HEADER) ||
             (state_q == ST_DATA) || (state_q == ST_GUARD);
    te_len = ctrl_q[CTRL_BLANK_BIT] ? 17'(TE_BLANK) : 17'(TE_NORMAL);
    te_tick = in_tx && (te_cnt_q == te_len - 17'h00001);
    ms_tick = (tick_cnt_q == 17'(MS_LEN - 1));
    tick_cnt_d = ms_tick ? 17'h00000 : tick_cnt_q + 17'h00001;

    state_d   = state_q;
    te_cnt_d  = te_tick ? 17'h00000 : (in_tx ? te_cnt_q + 17'h00001 : 17'h00000);
    elem_d    = elem_q;
    phase_d   = phase_q;
    word_d    = word_q;
    hop_d     = hop_q;
    pressed_d = pressed_q;
    repeat_d  = repeat_q;
    blank_d   = blank_q;
    shutoff_d = shutoff_q;
    ms_d      = ms_q;
    shut_d    = shut_q;
    start     = 1'b0;
    restart   = 1'b0;

    case (state_q)
      ST_IDLE: begin
        if (ctrl_q[CTRL_ENABLE_BIT] && btn != 4'h0) begin
          state_d   = ST_DEBOUNCE;
          ms_d      = 8'h00;
          pressed_d = 3'h0;
          repeat_d  = 1'b0;
          shutoff_d = 1'b0;
          shut_d    = 16'h0000;
        end
      end
      ST_DEBOUNCE: begin
        pressed_d = pressed_q | ext;
        if (btn == 4'h0) begin
          state_d = ST_IDLE;
        end else if (ms_tick) begin
          ms_d = ms_q + 8'h01;
          if (ms_q == 8'(DEBOUNCE_LEN - 1)) begin
            state_d = ST_DELAY;
          end
        end
      end
      ST_DELAY: begin
        pressed_d = pressed_q | ext;
        if (ms_tick) begin
          ms_d = ms_q + 8'h01;
          if (ms_q == 8'(DELAY_LEN - 1)) begin
            start = 1'b1;
          end
        end
      end
      ST_PREAMBLE, ST_HEADER, ST_DATA, ST_GUARD: begin
        if (!repeat_q && ((ext & ~pressed_q) != 3'h0)) begin
          pressed_d = pressed_q | ext;
          restart = 1'b1;
        end else if (te_tick) begin
          elem_d = elem_q + 8'h01;
          case (state_q)
            ST_PREAMBLE: if (elem_q == PREAMBLE_ELEMS - 8'h01) begin
              state_d = ST_HEADER;
              elem_d  = 8'h00;
            end
            ST_HEADER: if (elem_q == HEADER_ELEMS - 8'h01) begin
              state_d = ST_DATA;
              elem_d  = 8'h00;
              phase_d = 2'h0;
            end
            ST_DATA: begin
              phase_d = (phase_q == ELEMS_PER_BIT - 2'h1) ? 2'h0 : phase_q + 2'h1;
              if (phase_q == ELEMS_PER_BIT - 2'h1) begin
                word_d = {1'b0, word_q[WORD_BITS-1:1]};
              end
              if (elem_q == DATA_ELEMS - 8'h01) begin
                state_d = ST_GUARD;
                elem_d  = 8'h00;
              end
            end
            default: if (elem_q == GUARD_ELEMS - 8'h01) begin
              if (ctrl_q[CTRL_ENABLE_BIT] && btn != 4'h0) begin
                repeat_d = 1'b1;
                start    = 1'b1;
              end else begin
                state_d = ST_IDLE;
              end
            end
          endcase
        end
        if (ms_tick) begin
          shut_d = shut_q + 16'h0001;
          if (shut_q == 16'(SHUTOFF_LEN - 1) && btn != 4'h0) begin
            state_d   = ST_LOCKOUT;
            shutoff_d = 1'b1;
            start     = 1'b0;
            restart   = 1'b0;
          end
        end
      end
      ST_LOCKOUT: begin
        if (btn == 4'h0) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase

    // Merged buttons are mapped as one combination, not as an OR of codes
    code[3] = pressed_d[2];
    code[2] = pressed_d[2];
    code[1] = pressed_d[1] | (pressed_d[2] & pressed_d[0]);
    code[0] = pressed_d[0] & (~pressed_d[2] | pressed_d[1]);
    fifo_pop = start && fifo_out_valid;
    if (fifo_pop) begin
      hop_d = fifo_out_data;
    end
    if (start) begin
      blank_d = ctrl_q[CTRL_BLANK_BIT] ? ~blank_q : 1'b0;
    end
    if (start || restart) begin
      state_d  = ST_PREAMBLE;
      elem_d   = 8'h00;
      phase_d  = 2'h0;
      te_cnt_d = 17'h00000;
      word_d   = {(start ? repeat_d : repeat_q), low_battery_i, code[2], code[1], code[0], code[3],
                  serial_q,
                  (fifo_pop ? fifo_out_data : hop_q)};
    end

    // Output level for the element in progress; a blanked word stays low
    pwm_d = 1'b0;
    if (!blank_q) begin
      case (state_q)
        ST_PREAMBLE: pwm_d = ~elem_q[0];
        ST_DATA:     pwm_d = (phase_q == 2'h0) || (phase_q == 2'h1 && !word_q[0]);
        default:     pwm_d = 1'b0;
      endcase
    end
    txact_d = in_tx;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q    <= ST_IDLE;
      te_cnt_q   <= 17'h00000;
      elem_q     <= 8'h00;
      phase_q    <= 2'h0;
      word_q     <= '0;
      hop_q      <= HOP_RESET;
      pressed_q  <= 3'h0;
      repeat_q   <= 1'b0;
      blank_q    <= 1'b0;
      shutoff_q  <= 1'b0;
      ms_q       <= 8'h00;
      shut_q     <= 16'h0000;
      tick_cnt_q <= 17'h00000;
      pwm_q      <= 1'b0;
      txact_q    <= 1'b0;
    end else begin
      state_q    <= state_d;
      te_cnt_q   <= te_cnt_d;
      elem_q     <= elem_d;
      phase_q    <= phase_d;
      word_q     <= word_d;
      hop_q      <= hop_d;
      pressed_q  <= pressed_d;
      repeat_q   <= repeat_d;
      blank_q    <= blank_d;
      shutoff_q  <= shutoff_d;
      ms_q       <= ms_d;
      shut_q     <= shut_d;
      tick_cnt_q <= tick_cnt_d;
      pwm_q      <= pwm_d;
      txact_q    <= txact_d;
    end
  end

  assign pready_o    = pready_q;
  assign prdata_o    = prdata_q;
  assign pslverr_o   = pslverr_q;
  assign pwm_o       = pwm_q;
  assign tx_active_o = txact_q;
endmodule // code_word_transmit_framer

/* File: code_word_transmit_framer_props.sv */
`timescale 1ns/1ps

module code_word_transmit_framer_props
  import code_word_framer_pkg::*;
#(
  parameter int TE_NORMAL = 20,
  parameter int TE_BLANK  = 10,
  parameter int MS_LEN    = 50,
  parameter int DELAY_LEN = 4
) (
  // Clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  // APB slave
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  // Buttons and line
  input wire logic        button_in_zero_i,
  input wire logic        button_in_one_i,
  input wire logic        button_in_two_i,
  input wire logic        pwm_o,
  input wire logic        tx_active_o
);
  localparam int DLY_LO = (DELAY_LEN - 1) * MS_LEN;
  localparam int DLY_HI = (DELAY_LEN + 1) * MS_LEN + 3;
  logic [31:0] pos_q;
  logic        en_q;
  logic        blank_q;
  int          te;
  int          elem;
  int          phase;
  wire logic   btn_any = button_in_zero_i | button_in_one_i | button_in_two_i;
  wire logic [2:0] btns = {button_in_two_i, button_in_one_i, button_in_zero_i};
  logic [2:0]  held_q;
  logic        first_q;
  logic        rs_q;
  // A new button during the first word restarts it; element count realigns
  wire logic   restart = tx_active_o && first_q && ((btns & ~held_q) != 3'h0);
  assign te    = blank_q ? TE_BLANK : TE_NORMAL;
  assign elem  = pos_q / te;
  assign phase = (elem - 33) % 3;

  // Mirrors the control register and counts cycles within a word
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pos_q   <= '0;
      en_q    <= 1'b0;
      blank_q <= 1'b0;
      held_q  <= 3'h0;
      first_q <= 1'b1;
      rs_q    <= 1'b0;
    end else begin
      held_q  <= (!tx_active_o && !btn_any) ? 3'h0 : (held_q | btns);
      first_q <= !tx_active_o || (first_q && pos_q != 32'(270 * te - 1));
      rs_q    <= restart;
      if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == CTRL_OFFSET) begin
        en_q    <= pwdata_i[CTRL_ENABLE_BIT];
        blank_q <= pwdata_i[CTRL_BLANK_BIT];
      end
      pos_q <= (!tx_active_o || rs_q || pos_q == 32'(270 * te - 1)) ? '0 : pos_q + 32'h1;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_preamble_start: assert property ($rose(tx_active_o) && !blank_q |-> pwm_o)
    else $error("word did not open high");
  a_preamble_pattern: assert property (tx_active_o && !blank_q && elem < 23 |-> pwm_o == !elem[0])
    else $error("preamble pattern wrong");
  a_header_low: assert property (tx_active_o && elem >= 23 && elem < 33 |-> !pwm_o)
    else $error("header not low");
  a_bit_lead_high: assert property (tx_active_o && !blank_q && elem >= 33 && elem < 231 && phase == 0 |-> pwm_o)
    else $error("bit lead element not high");
  a_bit_tail_low: assert property (tx_active_o && elem >= 33 && elem < 231 && phase == 2 |-> !pwm_o)
    else $error("bit tail element not low");
  a_guard_low: assert property (tx_active_o && elem >= 231 |-> !pwm_o)
    else $error("guard not silent");
  a_element_steady: assert property (tx_active_o && pos_q % te != 0 |-> $stable(pwm_o))
    else $error("line moved inside an element");
  a_idle_quiet: assert property (!tx_active_o |-> !pwm_o)
    else $error("line active outside a word");
  a_start_delay: assert property ($rose(btn_any) && en_q && !tx_active_o |-> ##[DLY_LO:DLY_HI] $rose(tx_active_o))
    else $error("transmit delay out of range");
endmodule // code_word_transmit_framer_props

bind code_word_transmit_framer code_word_transmit_framer_props #(
  .TE_NORMAL(TE_NORMAL), .TE_BLANK(TE_BLANK), .MS_LEN(MS_LEN), .DELAY_LEN(DELAY_LEN)
) u_props (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .button_in_zero_i(button_in_zero_i),
  .button_in_one_i(button_in_one_i), .button_in_two_i(button_in_two_i), .pwm_o(pwm_o), .tx_active_o(tx_active_o)
);

/* File: code_word_transmit_framer_test.sv */
`timescale 1ns/1ps

module code_word_transmit_framer_test
  import code_word_framer_pkg::*;
;
  localparam int TEN = 20;
  localparam int TEB = 10;
  localparam int MSL = 50;
  localparam int SHL = 250;
  typedef struct packed {
    logic [2:0] first;
    logic [2:0] late;
    logic [3:0] code;
  } row_type;
  // Pressed buttons, buttons added during debounce, internal code expected
  row_type rows [7] = '{'{3'h1, 3'h0, 4'h1}, '{3'h2, 3'h0, 4'h2}, '{3'h1, 3'h2, 4'h3}, '{3'h4, 3'h0, 4'hC},
                        '{3'h1, 3'h4, 4'hE}, '{3'h6, 3'h0, 4'hE}, '{3'h7, 3'h0, 4'hF}};
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, low_battery_i = 1'b0, er;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [2:0]  btn = 3'h0;
  logic [15:0] te = 16'(TEN), rx_count, rx_bad, base, bad0;
  logic [65:0] rx_word, rx_last;
  logic        pready_o, pslverr_o, pwm_o, tx_active_o;
  int          n_mismatch = 0, cmp_count = 0, len;

  code_word_transmit_framer #(.TE_NORMAL(TEN), .TE_BLANK(TEB), .MS_LEN(MSL), .DEBOUNCE_LEN(2), .DELAY_LEN(4),
    .SHUTOFF_LEN(SHL)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .button_in_zero_i(btn[0]), .button_in_one_i(btn[1]), .button_in_two_i(btn[2]),
    .low_battery_i(low_battery_i), .pwm_o(pwm_o), .tx_active_o(tx_active_o));
  rf_receiver_model u_rx (.ref_clk_i(ref_clk_i), .te_i(te), .pwm_i(pwm_o), .word_o(rx_word),
    .words_o(rx_count), .bad_o(rx_bad));

  // Keeps the last complete word while a later one is being decoded
  always @(rx_count) rx_last = rx_word;

  initial forever #5 ref_clk_i = ~ref_clk_i;

  task automatic chk(input string nm, input logic [65:0] seen, input logic [65:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // Waits for a word to start, then counts its active cycles
  task automatic span();
    int n;
    n = 0;
    while (tx_active_o !== 1'b1 && n < 2000) begin
      @(posedge ref_clk_i);
      n++;
    end
    len = 0;
    while (tx_active_o === 1'b1 && len < 20000) begin
      @(posedge ref_clk_i);
      len++;
    end
  endtask

  // Press, optionally add buttons mid debounce, release once the word runs
  task automatic send(input logic [2:0] b, input logic [2:0] late);
    btn <= b;
    if (late != 3'h0) begin
      repeat (60) @(posedge ref_clk_i);
      btn <= b | late;
    end
    wait (tx_active_o === 1'b1);
    @(posedge ref_clk_i);
    btn <= 3'h0;
    span();
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (95000) @(posedge ref_clk_i);
    n_mismatch++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk("status_reset", 66'(rd), 66'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 66'({er, rd}), 66'h100000000);
    apb(1'b1, CTRL_OFFSET, 32'h1);
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, HOP_PUSH_OFFSET, 32'h5A3C0F00 + i);
      apb(1'b1, SERIAL_OFFSET, 32'h0123450 + i);
      low_battery_i <= i[0];
      send(rows[i].first, rows[i].late);
      chk("word_len", 66'(len), 66'(270 * TEN));
      chk("hop", 66'(rx_word[31:0]), 66'(32'h5A3C0F00 + i));
      chk("serial", 66'(rx_word[59:32]), 66'(28'h0123450 + i));
      chk("buttons", 66'({rx_word[60], rx_word[63:61]}), 66'(rows[i].code));
      chk("flags", 66'(rx_word[65:64]), 66'({1'b0, i[0]}));
      chk("format", 66'({rx_count, rx_bad}), 66'({16'(i + 1), 16'h0}));
    end
    // A button added during the first word restarts it with the merged code
    apb(1'b1, HOP_PUSH_OFFSET, 32'h13579BDF);
    btn <= 3'h1;
    wait (tx_active_o === 1'b1);
    @(posedge ref_clk_i);
    btn <= 3'h3;
    @(posedge ref_clk_i);
    btn <= 3'h0;
    span();
    chk("restart_len", 66'(len), 66'(270 * TEN + 2));
    chk("restart_word", 66'({rx_word[60], rx_word[63:61], rx_word[31:0]}), 66'({4'h3, 32'h13579BDF}));
    for (int k = 0; k < 8; k++)
      apb(1'b1, HOP_PUSH_OFFSET, 32'hC0DE0000 + k);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk("fifo_full", 66'(rd[11:8]), 66'h8);
    base = rx_count;
    btn <= 3'h1;
    apb(1'b1, HOP_PUSH_OFFSET, 32'hC0DE0008);
    span();
    chk("shutoff", 66'(len >= (SHL - 1) * MSL - 10 && len <= (SHL + 1) * MSL), 66'h1);
    chk("repeat", 66'({rx_count - base, rx_last[65], rx_last[31:0]}), 66'({16'h2, 1'b1, 32'hC0DE0001}));
    repeat (100) @(posedge ref_clk_i);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk("lockout", 66'({pwm_o, tx_active_o, rd[4], rd[11:8]}), 66'h16);
    btn <= 3'h0;
    repeat (4000) @(posedge ref_clk_i);
    apb(1'b1, CTRL_OFFSET, 32'h3);
    te   <= 16'(TEB);
    base = rx_count;
    bad0 = rx_bad;
    for (int k = 0; k < 8; k++) begin
      send(3'h2, 3'h0);
      chk("blank_len", 66'(len), 66'(270 * TEB));
    end
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk("drained", 66'({rx_count - base, rx_bad - bad0, rd[11:8]}), 66'({16'h4, 16'h0, 4'h0}));
    conclude();
  end
endmodule // code_word_transmit_framer_test

/* File: rf_receiver_model.sv */
`timescale 1ns/1ps

module rf_receiver_model (
  // Clock and element length in cycles
  input  wire logic        ref_clk_i,
  input  wire logic [15:0] te_i,
  // Serial line
  input  wire logic        pwm_i,
  // Decoded word, word count, bad elements
  output logic [65:0]      word_o,
  output logic [15:0]      words_o,
  output logic [15:0]      bad_o
);
  logic exp_bit;

  // Samples mid element; a blanked word never rises, so it is skipped
  initial begin
    word_o  = '0;
    words_o = '0;
    bad_o   = '0;
    forever begin
      @(posedge pwm_i);
      repeat (te_i / 2) @(posedge ref_clk_i);
      for (int e = 0; e < 270; e++) begin
        if (e >= 33 && e < 231 && (e - 33) % 3 == 1)
          word_o[(e - 33) / 3] = ~pwm_i;
        else begin
          exp_bit = (e < 23) ? ~e[0] : (e >= 33 && e < 231 && (e - 33) % 3 == 0);
          if (pwm_i !== exp_bit)
            bad_o++;
        end
        if (e < 269)
          repeat (te_i) @(posedge ref_clk_i);
      end
      words_o++;
    end
  end
endmodule // rf_receiver_model
